// File: logic/timer8_compare_waveform.sv
/*
  8-bit timer counter with compare unit, normal/ctc/fast pwm waveforms,
  overflow and compare flags and the port pin override, behind an APB slave.
  Assumes tick_i is a one-cycle timer clock enable from a prescaler on clock_i,
  and that the pin pad resolves level from pin_o.out and pin_o.oe.
*/
// What this block does
// - nonzero output mode overrides port output value
// - pin direction stays with port direction bit
// - override depends only on output mode
// - compare output state register, software initialisable
// - output mode zero leaves state unchanged
// - new output mode acts at next match
// - waveform mode alone sets count sequence
// - mode zero counts up, wraps FF to 00
// - normal overflow flag set when count zeroes
// - normal mode accepts count writes anytime
// - mode two clears count on compare match
// - ctc compare unbuffered, low write wraps first
// - ctc raises compare flag at top
// - ctc toggle mode flips output each match
// - ctc overflow flag set passing MAX
// - mode three counts up to MAX, wraps
// - fast pwm mode two/three set polarity
// - fast pwm overflow flag set at MAX
// - fast pwm period is 256 timer clocks
// - compare zero spikes, MAX gives constant level
// - fast pwm compare buffered until bottom
// - compare flag set one timer clock after
// - force strobe: output only, reads zero
`timescale 1ns/1ps
`include "timer8_defs.svh"

module timer8_compare_waveform
  import timer8_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire apb_req_type apb_i,
  output apb_rsp_type apb_o,
  output pin_drive_type pin_o
);

  logic [7:0] count_ff;
  logic [7:0] cmp_buf_ff;
  logic [7:0] cmp_act_ff;
  logic [1:0] wave_ff;
  logic [1:0] com_ff;
  logic oc_ff;
  logic block_ff;
  logic ovf_flag_ff;
  logic cmp_flag_ff;
  logic port_out_ff;
  logic port_dir_ff;
  logic pin_out_ff;
  logic pin_oe_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  logic setup;
  logic wr_fire;
  logic ctrl_wr;
  logic cnt_wr;
  logic cmp_wr;
  logic flag_wr;
  logic port_wr;
  logic pwm;
  logic match;
  logic match_ev;
  logic wrap_ev;
  logic force_ev;
  logic [1:0] com_eff;
  logic [1:0] wave_eff;
  logic [31:0] nxt_prdata;

  // true for the five mapped word addresses
  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == `OFS_MODE_CTRL) || (addr == `OFS_COUNT) ||
             (addr == `OFS_COMPARE) || (addr == `OFS_FLAGS) ||
             (addr == `OFS_PORT_CTRL);
  endfunction

  // apb decode; no wait state, yet every answer comes from a flop
  assign setup = apb_i.psel && !apb_i.penable;
  assign wr_fire = apb_i.psel && apb_i.penable && pready_ff && apb_i.pwrite;
  assign ctrl_wr = wr_fire && (apb_i.paddr == `OFS_MODE_CTRL);
  assign cnt_wr = wr_fire && (apb_i.paddr == `OFS_COUNT);
  assign cmp_wr = wr_fire && (apb_i.paddr == `OFS_COMPARE);
  assign flag_wr = wr_fire && (apb_i.paddr == `OFS_FLAGS);
  assign port_wr = wr_fire && (apb_i.paddr == `OFS_PORT_CTRL);

  // settings written in this very cycle steer a simultaneous strobe
  assign com_eff = ctrl_wr ? apb_i.pwdata[`COM_LSB +: 2] : com_ff;
  assign wave_eff = ctrl_wr ? apb_i.pwdata[`WAVE_LSB +: 2] : wave_ff;
  assign pwm = wave_ff[0];

  // a count write blocks the match in the following timer clock
  assign match = (count_ff == cmp_act_ff) && !block_ff;
  assign match_ev = tick_i && match && !cnt_wr;
  assign wrap_ev = tick_i && !cnt_wr && (count_ff == `COUNT_MAX);
  assign force_ev = ctrl_wr && apb_i.pwdata[`FORCE_BIT] && !wave_eff[0];

  // read data mux; the force strobe bit always reads zero
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    case (apb_i.paddr)
      `OFS_MODE_CTRL:
      begin
        nxt_prdata[`WAVE_LSB +: 2] = wave_ff;
        nxt_prdata[`COM_LSB +: 2] = com_ff;
      end
      `OFS_COUNT: nxt_prdata[7:0] = count_ff;
      `OFS_COMPARE: nxt_prdata[7:0] = cmp_buf_ff;
      `OFS_FLAGS:
      begin
        nxt_prdata[`FLAG_OVF] = ovf_flag_ff;
        nxt_prdata[`FLAG_CMP] = cmp_flag_ff;
      end
      `OFS_PORT_CTRL:
      begin
        nxt_prdata[`PORT_OUT_BIT] = port_out_ff;
        nxt_prdata[`PORT_DIR_BIT] = port_dir_ff;
        nxt_prdata[`PORT_OC_BIT] = oc_ff;
        nxt_prdata[`PORT_PIN_BIT] = pin_out_ff;
      end
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  // apb answer: ready in the first access cycle, error for unmapped addresses
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped(apb_i.paddr);
      prdata_ff <= setup ? nxt_prdata : 32'h0000_0000;
    end
  end

  // mode and output mode settings
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wave_ff <= `RST_WAVE;
      com_ff <= `RST_COM;
    end
    else if (ctrl_wr)
    begin
      wave_ff <= apb_i.pwdata[`WAVE_LSB +: 2];
      com_ff <= apb_i.pwdata[`COM_LSB +: 2];
    end
  end

  // counter; a cpu write wins over counting, sequence set by mode only
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      count_ff <= `RST_COUNT;
    else if (cnt_wr)
      count_ff <= apb_i.pwdata[7:0];
    else if (tick_i)
    begin
      case (wave_ff)
        `WAVE_CTC: count_ff <= match ? `COUNT_BOTTOM : count_ff + 8'h01;
        // normal and fast pwm wrap MAX to BOTTOM, 256 ticks a period
        default: count_ff <= count_ff + 8'h01;
      endcase
    end
  end

  // match blocking after a count write, even with the timer stopped
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      block_ff <= 1'b0;
    else if (cnt_wr)
      block_ff <= 1'b1;
    else if (tick_i)
      block_ff <= 1'b0;
  end

  // compare buffer; pwm modes copy it at bottom, others go straight through
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cmp_buf_ff <= `RST_COMPARE;
      cmp_act_ff <= `RST_COMPARE;
    end
    else
    begin
      if (cmp_wr)
        cmp_buf_ff <= apb_i.pwdata[7:0];
      if (cmp_wr && !pwm)
        cmp_act_ff <= apb_i.pwdata[7:0];
      else if (pwm && wrap_ev)
        cmp_act_ff <= cmp_buf_ff;
    end
  end

  // flags: hardware sets, software writes one to clear, a set wins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ovf_flag_ff <= 1'b0;
      cmp_flag_ff <= 1'b0;
    end
    else
    begin
      ovf_flag_ff <= (ovf_flag_ff && !(flag_wr && apb_i.pwdata[`FLAG_OVF])) ||
                     wrap_ev;
      cmp_flag_ff <= (cmp_flag_ff && !(flag_wr && apb_i.pwdata[`FLAG_CMP])) ||
                     match_ev;
    end
  end

  // compare output state; survives mode changes and is set up by forcing
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      oc_ff <= 1'b0;
    else if (!pwm || force_ev) // a force obeys the mode written with it
    begin
      if (match_ev || force_ev)
      begin
        case (com_eff)
          `COM_TOGGLE: oc_ff <= !oc_ff;
          `COM_CLEAR: oc_ff <= 1'b0;
          `COM_SET: oc_ff <= 1'b1;
          default: oc_ff <= oc_ff;
        endcase
      end
    end
    else if (wave_ff == `WAVE_FAST)
    begin
      // bottom beats a match at MAX, so compare MAX holds a constant level
      case (com_ff)
        `COM_CLEAR:
        begin
          if (wrap_ev)
            oc_ff <= 1'b1;
          else if (match_ev)
            oc_ff <= 1'b0;
        end
        `COM_SET:
        begin
          if (wrap_ev)
            oc_ff <= 1'b0;
          else if (match_ev)
            oc_ff <= 1'b1;
        end
        default: oc_ff <= oc_ff;
      endcase
    end
  end

  // port value and direction bits of the general port
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      port_out_ff <= 1'b0;
      port_dir_ff <= 1'b0;
    end
    else if (port_wr)
    begin
      port_out_ff <= apb_i.pwdata[`PORT_OUT_BIT];
      port_dir_ff <= apb_i.pwdata[`PORT_DIR_BIT];
    end
  end

  // pin drive; override follows output mode alone, direction from port bit
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      pin_out_ff <= (com_ff != `COM_NONE) ? oc_ff : port_out_ff;
      pin_oe_ff <= port_dir_ff;
    end
  end

  assign apb_o.prdata = prdata_ff;
  assign apb_o.pready = pready_ff;
  assign apb_o.pslverr = pslverr_ff;
  assign pin_o.out = pin_out_ff;
  assign pin_o.oe = pin_oe_ff;

  // pin shows the compare state whenever output mode is nonzero
  property p_override;
    @(posedge clock_i) disable iff (rst_i)
    (com_ff != `COM_NONE) && $stable(com_ff) |=> (pin_o.out == $past(oc_ff));
  endproperty
  a_override: assert property (p_override)
    else $error("pin does not follow compare state under override");

  // direction stays under the port bit
  property p_direction;
    @(posedge clock_i) disable iff (rst_i)
    1'b1 |=> (pin_o.oe == $past(port_dir_ff));
  endproperty
  a_direction: assert property (p_direction)
    else $error("pin direction not from port bit");

  // output mode zero never moves the compare state
  property p_com_zero_holds;
    @(posedge clock_i) disable iff (rst_i)
    (com_ff == `COM_NONE) && !ctrl_wr |=> $stable(oc_ff);
  endproperty
  a_com_zero_holds: assert property (p_com_zero_holds)
    else $error("compare state moved with output mode zero");

  // normal mode wraps and sets overflow in that cycle
  property p_normal_wrap;
    @(posedge clock_i) disable iff (rst_i)
    (wave_ff == `WAVE_NORMAL) && wrap_ev |=> (count_ff == `COUNT_BOTTOM) && ovf_flag_ff;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("normal mode wrap or overflow wrong");

  // ctc clears the count and raises the compare flag on a match
  property p_ctc_clear;
    @(posedge clock_i) disable iff (rst_i)
    (wave_ff == `WAVE_CTC) && match_ev |=> (count_ff == `COUNT_BOTTOM) && cmp_flag_ff;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("ctc did not clear on match");

  // fast pwm non-inverting output is high right after bottom
  property p_fast_bottom;
    @(posedge clock_i) disable iff (rst_i)
    (wave_ff == `WAVE_FAST) && (com_ff == `COM_CLEAR) && wrap_ev |=> oc_ff;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom)
    else $error("fast pwm output not set at bottom");

  // active compare in fast pwm only changes at bottom
  property p_buffered;
    @(posedge clock_i) disable iff (rst_i)
    (wave_ff == `WAVE_FAST) && !wrap_ev && !ctrl_wr |=> $stable(cmp_act_ff);
  endproperty
  a_buffered: assert property (p_buffered)
    else $error("active compare changed away from bottom");

  // forced match leaves the count alone and sets no compare flag
  property p_force_quiet;
    @(posedge clock_i) disable iff (rst_i)
    force_ev && !tick_i && !cmp_flag_ff && !flag_wr |=> $stable(count_ff) && !cmp_flag_ff;
  endproperty
  a_force_quiet: assert property (p_force_quiet)
    else $error("force strobe touched count or flag");

  // a match sets the compare flag at the next clock edge
  property p_flag_delay;
    @(posedge clock_i) disable iff (rst_i)
    match_ev |-> ##1 cmp_flag_ff ##1 (cmp_flag_ff || $past(flag_wr));
  endproperty
  a_flag_delay: assert property (p_flag_delay)
    else $error("compare flag not set after match");

endmodule

// File: logic/timer8_defs.svh
/*
  Constants of the 8-bit timer compare/waveform block: register offsets,
  field positions, reset values and mode codes.
  Assumes it is included by bare name from the design and the testbench.
*/
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH

// register byte offsets on the APB
`define OFS_MODE_CTRL 8'h00
`define OFS_COUNT 8'h04
`define OFS_COMPARE 8'h08
`define OFS_FLAGS 8'h0C
`define OFS_PORT_CTRL 8'h10

// mode_ctrl fields
`define WAVE_LSB 0
`define COM_LSB 2
`define FORCE_BIT 7

// flags fields
`define FLAG_OVF 0
`define FLAG_CMP 1

// port_ctrl fields
`define PORT_OUT_BIT 0
`define PORT_DIR_BIT 1
`define PORT_OC_BIT 2
`define PORT_PIN_BIT 3

// reset values
`define RST_COUNT 8'h00
`define RST_COMPARE 8'h00
`define RST_WAVE 2'h0
`define RST_COM 2'h0

// count extremes
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00

// waveform modes
`define WAVE_NORMAL 2'h0
`define WAVE_PHASE 2'h1
`define WAVE_CTC 2'h2
`define WAVE_FAST 2'h3

// compare output modes
`define COM_NONE 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

`endif

// File: logic/timer8_pkg.sv
/*
  Types shared by the timer compare/waveform block.
  Assumes timer8_defs.svh is on the include path.
*/
package timer8_pkg;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  // port pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

endpackage

// File: bench/pin_pad.sv
/*
  model of the port pin pad on the far side of the timer.
  assumes drive_i comes straight from the timer's pin port.
*/
`timescale 1ns/1ps

module pin_pad
  import timer8_pkg::*;
(
  input wire logic clock_i,
  input wire pin_drive_type drive_i,
  output logic level_o
);
  logic float_ff = 1'b0;

  // an undriven pad wanders, so a stale level never looks valid
  always_ff @(posedge clock_i)
    float_ff <= ~float_ff;

  // direction alone decides whether the pad shows the drive
  assign level_o = drive_i.oe ? drive_i.out : float_ff;
endmodule

// File: bench/test_timer8_compare_waveform.sv
/*
  self-checking testbench of the timer compare/waveform block.
  assumes timer8_defs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "timer8_defs.svh"

module test_timer8_compare_waveform
  import timer8_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic tick_i = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  pin_drive_type pin;
  logic level;
  logic [31:0] rd;
  logic err;
  int n_mismatch = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  timer8_compare_waveform DUT (.clock_i(clock_i), .rst_i(rst_i), .tick_i(tick_i),
    .apb_i(req), .apb_o(rsp), .pin_o(pin));
  pin_pad pad (.clock_i(clock_i), .drive_i(pin), .level_o(level));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer; the request stands until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    chk("pready", 1, rsp.pready);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // timer clock pulses with an idle cycle between them
  task tk(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      tick_i <= 1'b1;
      @(posedge clock_i);
      tick_i <= 1'b0;
    end
  endtask

  // compare output state reads back in port_ctrl bit 2
  task oc(input logic exp);
    xfer(1'b0, `OFS_PORT_CTRL, 32'h0);
    chk("oc_state", {31'h0, exp}, {31'h0, rd[2]});
  endtask

  // pin lags the registers by a clock, so let two edges pass first
  task pc(input logic oe, input logic lvl);
    repeat (2) @(posedge clock_i);
    chk("pin_oe", {31'h0, oe}, {31'h0, pin.oe});
    if (oe)
      chk("pad_level", {31'h0, lvl}, {31'h0, level});
  endtask

  function automatic logic [31:0] mc(input logic [1:0] wm, input logic [1:0] cm, input logic f);
    mc = 32'h0;
    mc[`FORCE_BIT] = f;
    mc[`COM_LSB +: 2] = cm;
    mc[`WAVE_LSB +: 2] = wm;
  endfunction

  task t_force;
    wr(`OFS_PORT_CTRL, 32'h2);
    wr(`OFS_MODE_CTRL, mc(`WAVE_NORMAL, `COM_SET, 1'b1));
    oc(1'b1);
    rc("mode_ctrl", `OFS_MODE_CTRL, mc(`WAVE_NORMAL, `COM_SET, 1'b0));
    rc("flags", `OFS_FLAGS, 32'h0);
    rc("count", `OFS_COUNT, 32'h0);
    pc(1'b1, 1'b1);
    wr(`OFS_MODE_CTRL, mc(`WAVE_FAST, `COM_NONE, 1'b0));
    pc(1'b1, 1'b0);
    wr(`OFS_MODE_CTRL, mc(`WAVE_FAST, `COM_CLEAR, 1'b0));
    pc(1'b1, 1'b1);
    wr(`OFS_PORT_CTRL, 32'h0);
    pc(1'b0, 1'b0);
    xfer(1'b0, 8'h40, 32'h0);
    chk("pslverr", 1, err);
    $display("t_force done");
  endtask

  task t_normal;
    wr(`OFS_MODE_CTRL, mc(`WAVE_NORMAL, `COM_NONE, 1'b0));
    wr(`OFS_COMPARE, 32'hFF);
    wr(`OFS_COUNT, 32'hFE);
    tk(1);
    rc("flags", `OFS_FLAGS, 32'h0);
    tk(1);
    rc("count", `OFS_COUNT, 32'h0);
    rc("flags", `OFS_FLAGS, 32'h3);
    oc(1'b1);
    wr(`OFS_FLAGS, 32'h3);
    rc("flags", `OFS_FLAGS, 32'h0);
    $display("t_normal done");
  endtask

  task t_ctc;
    wr(`OFS_MODE_CTRL, mc(`WAVE_CTC, `COM_TOGGLE, 1'b0));
    wr(`OFS_COMPARE, 32'h2);
    wr(`OFS_COUNT, 32'h5);
    tk(251);
    rc("count", `OFS_COUNT, 32'h0);
    rc("flags", `OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'h3);
    tk(3);
    rc("count", `OFS_COUNT, 32'h0);
    rc("flags", `OFS_FLAGS, 32'h2);
    oc(1'b0);
    tk(3);
    oc(1'b1);
    $display("t_ctc done");
  endtask

  task t_fast;
    wr(`OFS_MODE_CTRL, mc(`WAVE_NORMAL, `COM_NONE, 1'b0));
    wr(`OFS_COMPARE, 32'h80);
    wr(`OFS_COUNT, 32'h7F);
    wr(`OFS_MODE_CTRL, mc(`WAVE_FAST, `COM_CLEAR, 1'b0));
    tk(2);
    oc(1'b0);
    wr(`OFS_COMPARE, 32'h10);
    tk(126);
    rc("count", `OFS_COUNT, 32'hFF);
    wr(`OFS_FLAGS, 32'h3);
    tk(1);
    rc("flags", `OFS_FLAGS, 32'h1);
    oc(1'b1);
    wr(`OFS_COMPARE, 32'h40);
    tk(17);
    oc(1'b0);
    tk(256);
    rc("count", `OFS_COUNT, 32'h11);
    $display("t_fast done");
  endtask

  // new output mode waits for a match; extreme compare values; reserved combination
  task t_extreme;
    wr(`OFS_MODE_CTRL, mc(`WAVE_NORMAL, `COM_TOGGLE, 1'b0));
    oc(1'b1);
    wr(`OFS_COMPARE, 32'h12);
    tk(2);
    oc(1'b0);
    wr(`OFS_COMPARE, 32'hFF);
    wr(`OFS_MODE_CTRL, mc(`WAVE_FAST, `COM_CLEAR, 1'b0));
    tk(256);
    oc(1'b1);
    wr(`OFS_COMPARE, 32'h0);
    tk(237);
    oc(1'b1);
    tk(1);
    oc(1'b0);
    tk(255);
    oc(1'b1);
    // a force in fast pwm is ignored, and toggle there is reserved
    wr(`OFS_MODE_CTRL, mc(`WAVE_FAST, `COM_TOGGLE, 1'b1));
    oc(1'b1);
    tk(256);
    oc(1'b1);
    $display("t_extreme done");
  endtask

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence after a 16-cycle reset
  initial
  begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    t_force;
    t_normal;
    t_ctc;
    t_fast;
    t_extreme;
    stop_test;
  end

  // watchdog: the tests need a few thousand cycles, so this bound is loose
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    stop_test;
  end
endmodule
